// ==== hw/safe_base_block_monitor.sv ====
/*
 * Two-channel hardwired base-block interlock of a servo drive.
 * Assumes active-low safety request pins from an external safety unit,
 * an asynchronous connector-presence pin, and drive-core settings on i_clk.
 */
module safe_base_block_monitor
    import safe_bb_pkg::*;
#(
    parameter int unsigned REJECT_CYC = OFF_REJECT_CYC,
    parameter longint unsigned MISMATCH_LIMIT = MISMATCH_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_safety_request_ch1_n,
    input wire logic i_safety_request_ch2_n,
    input wire logic i_connector_present,
    input wire logic i_servo_on_req,
    input wire logic i_brake_release_req,
    input wire logic [15:0] i_brake_delay_setting,
    input wire logic [3:0] i_servo_off_stop_mode_setting,
    input wire logic i_fault_alarm_req,
    output logic o_gate_enable,
    output logic o_dyn_brake,
    output logic o_brake_release_out,
    output logic o_fault_alarm_out,
    output logic o_external_monitor_out,
    output logic o_show_base_block,
    output logic o_input_timing_alarm,
    output logic o_hardwired_base_block
);

    initial begin
        if (MISMATCH_LIMIT < 1) begin
            $error("MISMATCH_LIMIT must be at least 1");
        end
        if (MON_MAX_CYC < 2) begin
            $error("monitor deadline too short for pipeline");
        end
        // sync, filter and output stages must fit the deadline
        if (REJECT_CYC + 8 > MON_MAX_CYC) begin
            $error("off filter too slow for monitor deadline");
        end
    end

    localparam int MW = $clog2(MISMATCH_LIMIT + 2);

    chan_pair_t chan;
    logic conn_sync1_ff;
    logic conn_sync2_ff;
    bb_state_t state_ff;
    bb_state_t nxt_state;
    logic block_now;
    logic both_off;
    logic [MW-1:0] mismatch_cnt_ff;
    logic timing_alarm_ff;
    logic gate_ff;
    logic dyn_brake_ff;
    logic brake_ff;
    logic alarm_ff;
    logic monitor_ff;
    logic show_ff;
    logic hbb_ff;

    // ==========================================================
    // channel conditioning
    // ==========================================================
    chan_filter #(
        .REJECT_CYC(REJECT_CYC)
    ) u_ch1 (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_raw_on(~i_safety_request_ch1_n),
        .o_on(chan.ch1_on)
    );

    chan_filter #(
        .REJECT_CYC(REJECT_CYC)
    ) u_ch2 (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_raw_on(~i_safety_request_ch2_n),
        .o_on(chan.ch2_on)
    );

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            conn_sync1_ff <= 1'b0;
            conn_sync2_ff <= 1'b0;
        end else begin
            conn_sync1_ff <= i_connector_present;
            conn_sync2_ff <= conn_sync1_ff;
        end
    end

    // a missing connector leaves both channels open, forced here as well
    assign block_now = ~chan.ch1_on | ~chan.ch2_on | ~conn_sync2_ff;
    assign both_off = ~chan.ch1_on & ~chan.ch2_on;

    // ==========================================================
    // base-block state
    // ==========================================================
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_BLOCK: begin
                // leave only while servo-on is released after both channels return
                if (!block_now && !i_servo_on_req) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (block_now) begin
                    nxt_state = ST_BLOCK;
                end
            end
            default: begin
                nxt_state = ST_BLOCK;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_ff <= ST_BLOCK;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // channel mismatch timer
    // ==========================================================
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            mismatch_cnt_ff <= '0;
            timing_alarm_ff <= 1'b0;
        end else begin
            if (chan.ch1_on == chan.ch2_on) begin
                mismatch_cnt_ff <= '0;
            end else if (mismatch_cnt_ff < MW'(MISMATCH_LIMIT)) begin
                mismatch_cnt_ff <= mismatch_cnt_ff + MW'(1);
            end else begin
                timing_alarm_ff <= 1'b1;
            end
        end
    end

    // ==========================================================
    // drive side outputs
    // ==========================================================
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            gate_ff <= 1'b0;
            dyn_brake_ff <= 1'b0;
            show_ff <= RST_BLOCK;
            hbb_ff <= RST_BLOCK;
        end else begin
            gate_ff <= ~block_now && state_ff == ST_RUN && i_servo_on_req;
            dyn_brake_ff <= block_now && (i_servo_off_stop_mode_setting == STOP_DB_A
                || i_servo_off_stop_mode_setting == STOP_DB_B);
            show_ff <= block_now;
            hbb_ff <= block_now;
        end
    end

    // brake release drops in the same cycle, delay setting not consulted
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            brake_ff <= 1'b0;
        end else begin
            brake_ff <= i_brake_release_req && !block_now;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            alarm_ff <= 1'b0;
        end else begin
            alarm_ff <= (i_fault_alarm_req || timing_alarm_ff) && !block_now;
        end
    end

    // monitor follows both-off after filter; well inside the deadline
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            monitor_ff <= 1'b0;
        end else begin
            monitor_ff <= both_off;
        end
    end

    assign o_gate_enable = gate_ff;
    assign o_dyn_brake = dyn_brake_ff;
    assign o_brake_release_out = brake_ff;
    assign o_fault_alarm_out = alarm_ff;
    assign o_external_monitor_out = monitor_ff;
    assign o_show_base_block = show_ff;
    assign o_input_timing_alarm = timing_alarm_ff;
    assign o_hardwired_base_block = hbb_ff;

    logic unused_ok;
    assign unused_ok = ^i_brake_delay_setting;

endmodule : safe_base_block_monitor

// ==== hw/safe_bb_pkg.sv ====
/*
 * Shared constants and carrier types for the safe base-block monitor.
 * Assumes a single 25 MHz control clock; times are converted to cycle counts here.
 */
package safe_bb_pkg;

    // ==========================================================
    // clock and timing
    // ==========================================================
    localparam int unsigned CLK_HZ = 25000000;
    // off pulse width that must be rejected, in microseconds
    localparam int unsigned OFF_REJECT_US = 500;
    localparam int unsigned OFF_REJECT_CYC = (OFF_REJECT_US * (CLK_HZ / 1000000));
    // monitor output must rise within this many microseconds
    localparam int unsigned MON_MAX_US = 8000;
    localparam int unsigned MON_MAX_CYC = (MON_MAX_US * (CLK_HZ / 1000000));
    // channel mismatch tolerance, in milliseconds
    localparam int unsigned MISMATCH_MS = 10000;
    localparam longint unsigned MISMATCH_CYC = (64'(MISMATCH_MS) * 64'(CLK_HZ / 1000));

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic RST_CH_ON = 1'b0;
    localparam logic RST_BLOCK = 1'b1;

    // ==========================================================
    // stop mode encoding
    // ==========================================================
    localparam logic [3:0] STOP_DB_A = 4'h0;
    localparam logic [3:0] STOP_DB_B = 4'h1;

    typedef enum {
        ST_BLOCK,
        ST_RUN
    } bb_state_t;

    // filtered channel view: 1 means channel is on (current flows)
    typedef struct packed {
        logic ch1_on;
        logic ch2_on;
    } chan_pair_t;

    // outputs toward the drive core
    typedef struct packed {
        logic gate_enable;
        logic dyn_brake;
        logic show_base_block;
    } drive_ctl_t;

endpackage : safe_bb_pkg

// ==== hw/chan_filter.sv ====
/*
 * One safety request channel: two-flop synchroniser then off-pulse rejection.
 * Assumes the raw input is asynchronous to i_clk; high means channel on.
 */
module chan_filter
    import safe_bb_pkg::*;
#(
    parameter int unsigned REJECT_CYC = OFF_REJECT_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_raw_on,
    output logic o_on
);

    initial begin
        if (REJECT_CYC < 1) begin
            $error("REJECT_CYC must be at least 1");
        end
    end

    localparam int CW = $clog2(REJECT_CYC + 2);

    logic sync1_ff;
    logic sync2_ff;
    logic [CW-1:0] off_cnt_ff;
    logic on_ff;

    // ==========================================================
    // synchroniser
    // ==========================================================
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sync1_ff <= RST_CH_ON;
            sync2_ff <= RST_CH_ON;
        end else begin
            sync1_ff <= i_raw_on;
            sync2_ff <= sync1_ff;
        end
    end

    // ==========================================================
    // off interval must exceed the reject width
    // ==========================================================
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            off_cnt_ff <= '0;
            on_ff <= RST_CH_ON;
        end else if (sync2_ff) begin
            off_cnt_ff <= '0;
            on_ff <= 1'b1;
        end else if (off_cnt_ff <= CW'(REJECT_CYC)) begin
            off_cnt_ff <= off_cnt_ff + CW'(1);
        end else begin
            on_ff <= 1'b0;
        end
    end

    assign o_on = on_ff;

endmodule : chan_filter

// ==== tb/safe_bb_properties.sv ====
/* port checker for the base-block monitor
   bound to safe_base_block_monitor, one clock */
module safe_bb_properties
    import safe_bb_pkg::*;
#(
    parameter int unsigned REJECT_CYC = OFF_REJECT_CYC,
    parameter longint unsigned MISMATCH_LIMIT = MISMATCH_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_safety_request_ch1_n,
    input wire logic i_safety_request_ch2_n,
    input wire logic i_connector_present,
    input wire logic [3:0] i_servo_off_stop_mode_setting,
    input wire logic o_gate_enable,
    input wire logic o_dyn_brake,
    input wire logic o_brake_release_out,
    input wire logic o_fault_alarm_out,
    input wire logic o_external_monitor_out,
    input wire logic o_show_base_block,
    input wire logic o_input_timing_alarm,
    input wire logic o_hardwired_base_block
);
    // ==========
    // pin history counters
    localparam int unsigned K = REJECT_CYC + 8;
    logic [31:0] c1_ff, c2_ff, dif_ff, run_ff;
    function automatic logic [31:0] step(input logic [31:0] c, input logic en);
        return en ? c + 32'(c != '1) : '0;
    endfunction : step
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            {c1_ff, c2_ff, dif_ff, run_ff} <= '0;
        end else begin
            c1_ff <= step(c1_ff, i_safety_request_ch1_n);
            c2_ff <= step(c2_ff, i_safety_request_ch2_n);
            dif_ff <= step(dif_ff, i_safety_request_ch1_n != i_safety_request_ch2_n);
            run_ff <= step(run_ff, 1'b1);
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_bb;
        o_hardwired_base_block && $past(o_hardwired_base_block) && run_ff > 2;
    endsequence
    AST_BB_ENTRY: assert property ((c1_ff > K || c2_ff > K) |-> o_hardwired_base_block)
        else $error("base block not entered");
    AST_BB_BRAKE_ALARM: assert property (s_bb |-> !o_brake_release_out && !o_fault_alarm_out)
        else $error("brake or alarm active in base block");
    AST_BB_DRIVE: assert property (s_bb |-> !o_gate_enable && o_show_base_block)
        else $error("drive active in base block");
    AST_BB_BRAKE_NOW: assert property ($rose(o_hardwired_base_block) |-> !o_brake_release_out)
        else $error("brake release late at base block entry");
    AST_BB_DYN: assert property ((s_bb and ($past(i_servo_off_stop_mode_setting) <= 4'h1)) |-> o_dyn_brake)
        else $error("dynamic brake missing");
    AST_MON_ON: assert property (c1_ff > K && c2_ff > K |-> o_external_monitor_out)
        else $error("monitor late");
    AST_MON_ROSE: assert property ($rose(o_external_monitor_out) && run_ff > 8
        |-> c1_ff >= REJECT_CYC && c2_ff >= REJECT_CYC)
        else $error("monitor without both off");
    AST_TIMING: assert property (dif_ff > MISMATCH_LIMIT + REJECT_CYC + 16 |-> o_input_timing_alarm)
        else $error("timing alarm missing");
    AST_NO_CONN: assert property (!i_connector_present [*6] |-> !o_gate_enable && o_show_base_block)
        else $error("drive without connector");
    cover property ($rose(o_external_monitor_out));
    cover property ($rose(o_input_timing_alarm));
    cover property ($fell(o_hardwired_base_block));
endmodule : safe_bb_properties

bind safe_base_block_monitor safe_bb_properties #(
    .REJECT_CYC(REJECT_CYC), .MISMATCH_LIMIT(MISMATCH_LIMIT)
) safe_bb_properties_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_connector_present(i_connector_present),
    .i_safety_request_ch1_n(i_safety_request_ch1_n),
    .i_safety_request_ch2_n(i_safety_request_ch2_n),
    .i_servo_off_stop_mode_setting(i_servo_off_stop_mode_setting),
    .o_gate_enable(o_gate_enable), .o_dyn_brake(o_dyn_brake),
    .o_brake_release_out(o_brake_release_out), .o_fault_alarm_out(o_fault_alarm_out),
    .o_external_monitor_out(o_external_monitor_out), .o_show_base_block(o_show_base_block),
    .o_input_timing_alarm(o_input_timing_alarm), .o_hardwired_base_block(o_hardwired_base_block)
);

// ==== tb/safety_unit_model.sv ====
/* safety unit driving both request pins
   assumes pin high = channel off */
module safety_unit_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_open1,
    input wire logic i_open2,
    input wire logic i_monitor,
    output logic o_ch1_n,
    output logic o_ch2_n,
    output logic o_mismatch
);
    // ==========
    // interlock: keep both off until monitor answers
    logic hold_ff;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            hold_ff <= 1'b0;
        end else if (i_open1 && i_open2) begin
            hold_ff <= 1'b1;
        end else if (i_monitor) begin
            hold_ff <= 1'b0;
        end
    end
    assign o_ch1_n = i_open1 || hold_ff;
    assign o_ch2_n = i_open2 || hold_ff;
    assign o_mismatch = (o_ch1_n && o_ch2_n) != i_monitor;
endmodule : safety_unit_model

// ==== tb/safe_base_block_monitor_test.sv ====
/* self-checking bench for the base-block monitor
   assumes short filter and mismatch counts set below */
module safe_base_block_monitor_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned REJ = 20;
    localparam int unsigned MIS = 200;
    logic i_clk = 1'b0, i_reset = 1'b1, open1 = 1'b0, open2 = 1'b0;
    logic conn = 1'b1, son = 1'b0, breq = 1'b1, areq = 1'b0;
    logic [3:0] mode = 4'h0;
    logic [15:0] delay = 16'h0;
    logic gate, dbrk, brk, fault_alarm_out, mon, show, talm, bb, ch1_n, ch2_n, mism;
    int error_cnt = 0;
    int n_checks = 0;
    int seed = 45;
    always #20 i_clk = ~i_clk;
    safe_base_block_monitor #(.REJECT_CYC(REJ), .MISMATCH_LIMIT(64'(MIS)))
    safe_base_block_monitor_inst (
        .i_clk(i_clk), .i_reset(i_reset), .i_safety_request_ch1_n(ch1_n),
        .i_safety_request_ch2_n(ch2_n), .i_connector_present(conn), .i_servo_on_req(son),
        .i_brake_release_req(breq), .i_brake_delay_setting(delay),
        .i_servo_off_stop_mode_setting(mode), .i_fault_alarm_req(areq),
        .o_gate_enable(gate), .o_dyn_brake(dbrk), .o_brake_release_out(brk),
        .o_fault_alarm_out(fault_alarm_out), .o_external_monitor_out(mon), .o_show_base_block(show),
        .o_input_timing_alarm(talm), .o_hardwired_base_block(bb)
    );
    safety_unit_model safety_unit_model_inst (
        .i_clk(i_clk), .i_reset(i_reset), .i_open1(open1), .i_open2(open2),
        .i_monitor(mon), .o_ch1_n(ch1_n), .o_ch2_n(ch2_n), .o_mismatch(mism)
    );
    task automatic chk(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc
    // servo off for a moment, then on
    task automatic run_up();
        son = 1'b0;
        cyc(6);
        son = 1'b1;
        cyc(3);
    endtask : run_up
    function automatic logic exp_db(input logic [3:0] m);
        return m <= 4'h1;
    endfunction : exp_db
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    // ==========
    // main sequence
    initial begin
        cyc(11);
        chk(bb, 1'b1);
        chk(show, 1'b1);
        chk(gate, 1'b0);
        cyc(1);
        i_reset = 1'b0;
        run_up();
        chk(gate, 1'b1);
        $display("test bring_up done");
        for (int m = 0; m < 4; m++) begin
            mode = (m < 2) ? 4'(m) : 4'($random(seed));
            delay = 16'($random(seed));
            if (m[0]) son = 1'b0;
            cyc(2);
            areq = 1'($random(seed));
            open1 = 1'b1;
            cyc(($random(seed) & 3));
            open2 = 1'b1;
            cyc(REJ + 6);
            chk(bb, 1'b1);
            chk(brk, 1'b0);
            chk(fault_alarm_out, 1'b0);
            chk(gate, 1'b0);
            chk(show, 1'b1);
            chk(dbrk, exp_db(mode));
            cyc(4);
            chk(mon, 1'b1);
            chk(mism, 1'b0);
            open1 = 1'b0;
            open2 = 1'b0;
            areq = 1'b0;
            cyc(8);
            chk(mon, 1'b0);
            run_up();
            chk(gate, 1'b1);
            $display("test stop_mode done");
        end
        open1 = 1'b1;
        cyc(REJ);
        open1 = 1'b0;
        cyc(REJ + 8);
        chk(bb, 1'b0);
        chk(gate, 1'b1);
        chk(brk, 1'b1);
        chk(show, 1'b0);
        chk(dbrk, 1'b0);
        chk(mon, 1'b0);
        chk(mism, 1'b0);
        areq = 1'b1;
        cyc(2);
        chk(fault_alarm_out, 1'b1);
        areq = 1'b0;
        $display("test short_pulse done");
        conn = 1'b0;
        cyc(8);
        chk(gate, 1'b0);
        chk(show, 1'b1);
        conn = 1'b1;
        cyc(8);
        run_up();
        chk(gate, 1'b1);
        $display("test connector done");
        open1 = 1'b1;
        cyc(REJ + 20);
        chk(talm, 1'b0);
        chk(bb, 1'b1);
        cyc(MIS);
        chk(talm, 1'b1);
        open1 = 1'b0;
        cyc(8);
        chk(talm, 1'b1);
        chk(fault_alarm_out, 1'b1);
        $display("test mismatch done");
        end_of_test();
    end
    initial begin
        cyc(5000);
        error_cnt++;
        end_of_test();
    end
endmodule : safe_base_block_monitor_test
